// ==== core/alr_pkg.sv ====
package alr_pkg;

  // System clock and default line rate
  localparam int CLK_HZ = 20_000_000;
  localparam int DEF_BAUD = 9600;
  localparam int DEF_BIT_CYC = CLK_HZ / DEF_BAUD;
  localparam int CNT_W = 16;

  // Register selects on the register port
  localparam logic [1:0] REG_RX_CTL = 2'h0;
  localparam logic [1:0] REG_RX_CHAR = 2'h1;
  localparam logic [1:0] REG_TX_CTL = 2'h2;
  localparam logic [1:0] REG_TX_CHAR = 2'h3;

  // Field positions
  localparam int RXC_ADV_BIT = 0;
  localparam int RXC_DONE_BIT = 7;
  localparam int RXD_ERR_BIT = 15;
  localparam int RXD_OVR_BIT = 14;
  localparam int RXD_FRM_BIT = 13;
  localparam int RXD_PAR_BIT = 12;
  localparam int TXC_RDY_BIT = 7;
  localparam int TXC_IE_BIT = 6;
  localparam int TXC_LOOP_BIT = 2;
  localparam int TXC_BRK_BIT = 0;

  // Reset values
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;

  // Longest frame: start, 8 data, parity, 2 stop
  localparam int FRAME_W = 12;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } alr_rx_state_e;

  // Data bits per character: select 0..3 gives 5..8
  function automatic logic [3:0] alr_nbits(input logic [1:0] sel);
    return 4'h5 + {2'b00, sel};
  endfunction

  function automatic logic [7:0] alr_mask(input logic [1:0] sel);
    return 8'hFF >> (2'h3 - sel);
  endfunction

endpackage

// ==== core/alr_tx_shift.sv ====
`timescale 1ns/1ps
module alr_tx_shift
  import alr_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic [1:0] data_sel,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic two_stop,
  input wire logic [CW-1:0] bit_cyc,
  output logic busy,
  output logic line
);

  logic [FRAME_W-1:0] frame;
  logic [FRAME_W-1:0] shreg_r;
  logic [3:0] len;
  logic [3:0] nb;
  logic [3:0] left_r;
  logic [CW-1:0] cnt_r;
  logic par_bit;

  // Start bit, data LSB first, optional parity, stop bits as mark fill
  always_comb begin
    nb = alr_nbits(data_sel);
    par_bit = (^(data & alr_mask(data_sel))) ^ par_odd;
    frame = '1;
    frame[0] = LINE_SPACE;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nb) begin
        frame[i + 1] = data[i];
      end
    end
    if (par_en) begin
      frame[nb + 4'h1] = par_bit;
    end
    len = 4'h2 + nb + {3'b000, par_en} + {3'b000, two_stop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      shreg_r <= '1;
      left_r <= 4'h0;
      cnt_r <= '0;
      line <= LINE_MARK;
    end else if (load && !busy) begin
      busy <= 1'b1;
      shreg_r <= frame;
      left_r <= len;
      cnt_r <= bit_cyc - CW'(1);
      line <= frame[0];
    end else if (busy) begin
      if (cnt_r == '0) begin
        cnt_r <= bit_cyc - CW'(1);
        shreg_r <= {1'b1, shreg_r[FRAME_W-1:1]};
        line <= (left_r == 4'h1) ? LINE_MARK : shreg_r[1];
        left_r <= left_r - 4'h1;
        busy <= (left_r != 4'h1);
      end else begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

endmodule

// ==== core/alr_line_if.sv ====
`timescale 1ns/1ps
// Behaviour
// - reader advance clears at start mid, init
// - bit 15 is OR of errors
// - summary bit read-only, follows error flags
// - overrun when done still set at arrival
// - framing flag when stop bit missing
// - parity flag on mismatch, zero if disabled
// - error flags hold until next character
// - data right-justified, unused bits zero
// - received data not cleared by init
// - ready when buffer free; with enable, request
// - ready set by init, cleared by load
// - interrupt enable read/write, init clears
// - loopback feeds transmitter output to receiver
// - loopback runs receiver at transmit rate
// - break drives line to space
// - done cleared by read, advance, init
module alr_line_if
  import alr_pkg::*;
#(
  parameter int RX_BIT_CYC = DEF_BIT_CYC,
  parameter int TX_BIT_CYC = DEF_BIT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [1:0] REG_SEL,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic [1:0] CFG_DATA_SEL,
  input wire logic CFG_PARITY_EN,
  input wire logic CFG_PARITY_ODD,
  input wire logic CFG_TWO_STOP,
  input wire logic RX_LINE,
  output logic TX_LINE,
  output logic XMIT_IRQ,
  output logic READER_ADVANCE
);

  localparam int RDY_LO = 2;
  localparam int RDY_HI = 3;

  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_in;
  logic [CNT_W-1:0] rx_div;
  alr_rx_state_e rx_state_r;
  logic [CNT_W-1:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [7:0] rx_sh_r;
  logic rx_par_bad_r;
  logic rx_cap;
  logic rx_start_mid;
  logic [3:0] rx_nb;

  logic [7:0] rx_data_r;
  logic ovr_r;
  logic frm_r;
  logic par_r;
  logic done_r;
  logic adv_r;

  logic ie_r;
  logic loop_r;
  logic brk_r;
  logic rdy_r;
  logic [7:0] hold_r;
  logic hold_full_r;
  logic xfer;
  logic tx_busy;
  logic tx_ser;
  logic tx_line_r;
  logic irq_r;
  logic [15:0] rdata_r;

  logic wr_rxc;
  logic wr_txc;
  logic wr_txd;
  logic rd_rxd;
  logic got_r;

  assign wr_rxc = REG_WR && (REG_SEL == REG_RX_CTL);
  assign wr_txc = REG_WR && (REG_SEL == REG_TX_CTL);
  assign wr_txd = REG_WR && (REG_SEL == REG_TX_CHAR);
  assign rd_rxd = REG_RD && (REG_SEL == REG_RX_CHAR);

  // Line input synchroniser; only the second stage is looked at
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rx_s1_r <= LINE_MARK;
      rx_s2_r <= LINE_MARK;
    end else begin
      rx_s1_r <= RX_LINE;
      rx_s2_r <= rx_s1_r;
    end
  end

  // Loopback takes the transmitter's driven line, break included
  assign rx_in = loop_r ? tx_line_r : rx_s2_r;
  assign rx_div = loop_r ? CNT_W'(TX_BIT_CYC) : CNT_W'(RX_BIT_CYC);
  assign rx_nb = alr_nbits(CFG_DATA_SEL);
  assign rx_start_mid = (rx_state_r == RX_START) && (rx_cnt_r == '0) &&
                        !rx_in;
  assign rx_cap = (rx_state_r == RX_STOP) && (rx_cnt_r == '0);

  // Receiver: sample each bit at its centre
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= ZERO_BYTE;
      rx_par_bad_r <= 1'b0;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          if (!rx_in) begin
            rx_state_r <= RX_START;
            rx_cnt_r <= (rx_div >> 1) - CNT_W'(1);
          end
        end
        RX_START: begin
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - CNT_W'(1);
          end else if (!rx_in) begin
            rx_state_r <= RX_DATA;
            rx_cnt_r <= rx_div - CNT_W'(1);
            rx_idx_r <= 4'h0;
            rx_sh_r <= ZERO_BYTE;
            rx_par_bad_r <= 1'b0;
          end else begin
            // Glitch shorter than half a bit
            rx_state_r <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - CNT_W'(1);
          end else begin
            rx_cnt_r <= rx_div - CNT_W'(1);
            rx_sh_r[rx_idx_r[2:0]] <= rx_in;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == rx_nb - 4'h1) begin
              rx_state_r <= CFG_PARITY_EN ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - CNT_W'(1);
          end else begin
            rx_cnt_r <= rx_div - CNT_W'(1);
            rx_par_bad_r <= rx_in != ((^rx_sh_r) ^ CFG_PARITY_ODD);
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          // Character completes at the centre of the first stop bit
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - CNT_W'(1);
          end else begin
            rx_state_r <= RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Received word: init leaves data and error flags alone
  always_ff @(posedge SYS_CLK) begin
    if (rx_cap) begin
      rx_data_r <= rx_sh_r & alr_mask(CFG_DATA_SEL);
      got_r <= 1'b1;
      ovr_r <= done_r;
      frm_r <= !rx_in;
      par_r <= CFG_PARITY_EN && rx_par_bad_r;
    end
  end

  // Completion wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      done_r <= 1'b0;
    end else if (rx_cap) begin
      done_r <= 1'b1;
    end else if (rd_rxd || adv_r) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      adv_r <= 1'b0;
    end else if (rx_start_mid) begin
      adv_r <= 1'b0;
    end else if (wr_rxc && REG_WDATA[RXC_ADV_BIT]) begin
      adv_r <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ie_r <= 1'b0;
      loop_r <= 1'b0;
      brk_r <= 1'b0;
    end else if (wr_txc) begin
      ie_r <= REG_WDATA[TXC_IE_BIT];
      loop_r <= REG_WDATA[TXC_LOOP_BIT];
      brk_r <= REG_WDATA[TXC_BRK_BIT];
    end
  end

  // Double buffer: holding byte moves to the shifter when it is idle
  assign xfer = hold_full_r && !tx_busy;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      hold_r <= ZERO_BYTE;
      hold_full_r <= 1'b0;
    end else if (wr_txd) begin
      hold_r <= REG_WDATA[7:0];
      hold_full_r <= 1'b1;
    end else if (xfer) begin
      hold_full_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdy_r <= 1'b1;
    end else if (wr_txd) begin
      rdy_r <= 1'b0;
    end else if (xfer) begin
      rdy_r <= 1'b1;
    end
  end

  // Request is a level; it rises one cycle after ready while enabled
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= rdy_r && ie_r;
    end
  end

  alr_tx_shift #(
    .CW(CNT_W)
  ) u_tx (
    .clk(SYS_CLK),
    .rst(RESET),
    .load(xfer),
    .data(hold_r),
    .data_sel(CFG_DATA_SEL),
    .par_en(CFG_PARITY_EN),
    .par_odd(CFG_PARITY_ODD),
    .two_stop(CFG_TWO_STOP),
    .bit_cyc(CNT_W'(TX_BIT_CYC)),
    .busy(tx_busy),
    .line(tx_ser)
  );

  // Ready keeps pacing while break holds the line, so break length
  // can be timed by dummy characters
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tx_line_r <= LINE_MARK;
    end else begin
      tx_line_r <= brk_r ? LINE_SPACE : tx_ser;
    end
  end

  // Read data registered; transmit buffer reads as zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdata_r <= ZERO_WORD;
    end else if (REG_RD) begin
      rdata_r <= ZERO_WORD;
      case (REG_SEL)
        REG_RX_CTL: rdata_r[RXC_DONE_BIT] <= done_r;
        REG_RX_CHAR: begin
          rdata_r[RXD_ERR_BIT] <= ovr_r | frm_r | par_r;
          rdata_r[RXD_OVR_BIT] <= ovr_r;
          rdata_r[RXD_FRM_BIT] <= frm_r;
          rdata_r[RXD_PAR_BIT] <= par_r;
          rdata_r[7:0] <= rx_data_r;
        end
        REG_TX_CTL: begin
          rdata_r[TXC_RDY_BIT] <= rdy_r;
          rdata_r[TXC_IE_BIT] <= ie_r;
          rdata_r[TXC_LOOP_BIT] <= loop_r;
          rdata_r[TXC_BRK_BIT] <= brk_r;
        end
        default: rdata_r <= ZERO_WORD;
      endcase
    end
  end

  assign REG_RDATA = rdata_r;
  assign TX_LINE = tx_line_r;
  assign XMIT_IRQ = irq_r;
  assign READER_ADVANCE = adv_r;

  sequence load_seq;
    wr_txd ##1 !rdy_r;
  endsequence

  sequence idle_load_seq;
    wr_txd && !hold_full_r && !tx_busy && !xfer;
  endsequence

  // Word checks wait for a first character: data and flags have no reset
  err_summary_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    got_r && rd_rxd |=> REG_RDATA[RXD_ERR_BIT] ==
      ($past(ovr_r) | $past(frm_r) | $past(par_r)))
    else $error("error summary bit mismatch");
  overrun_set_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rx_cap && done_r |=> ovr_r && done_r)
    else $error("overrun not flagged");
  framing_set_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rx_cap |=> frm_r == !$past(rx_in))
    else $error("framing flag wrong");
  parity_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rx_cap && !CFG_PARITY_EN |=> !par_r)
    else $error("parity flag set with parity off");
  flags_hold_a: assert property (@(posedge SYS_CLK)
    got_r && !rx_cap |=> $stable({ovr_r, frm_r, par_r, rx_data_r}))
    else $error("received word changed without a character");
  data_mask_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rx_cap |=> (rx_data_r & ~alr_mask($past(CFG_DATA_SEL))) == ZERO_BYTE)
    else $error("unused data bits not zero");
  adv_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rx_start_mid && adv_r |=> !adv_r && !done_r)
    else $error("reader advance not cleared at start");
  done_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (rd_rxd || adv_r) && !rx_cap |=> !done_r)
    else $error("receive done not cleared");
  ready_load_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    wr_txd |-> load_seq)
    else $error("ready not cleared by load");
  ready_back_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    idle_load_seq |-> ##[RDY_LO:RDY_HI] rdy_r)
    else $error("ready did not return after transfer");
  irq_follow_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $rose(rdy_r) && ie_r && !wr_txc |=> XMIT_IRQ)
    else $error("no request on rising ready");
  init_state_a: assert property (@(posedge SYS_CLK)
    RESET |=> rdy_r && !ie_r && !loop_r && !brk_r && !adv_r && !done_r)
    else $error("initialise left control bits wrong");
  break_line_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    brk_r [*2] |-> !TX_LINE)
    else $error("break did not hold space");
  loop_path_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    loop_r |-> rx_in == tx_line_r && rx_div == CNT_W'(TX_BIT_CYC))
    else $error("loopback path or rate wrong");

endmodule

// ==== dv/alr_term.sv ====
`timescale 1ns/1ps
module alr_term #(
  parameter int TX_CYC = 8,
  parameter int RX_CYC = 8
) (
  input wire logic clk,
  output logic line_out,
  input wire logic line_in
);
  initial line_out = 1'b1;

  // One frame into the device; bp/bs corrupt parity or stop on purpose
  task automatic send(input logic [7:0] d, input int n, input logic pe,
    input logic po, input logic bp, input logic bs);
    logic [11:0] f;
    int len;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) begin
      f[1+i] = d[i];
    end
    len = 1 + n;
    if (pe) begin
      f[len] = ^(f[8:1] & (8'hFF >> (8 - n))) ^ po ^ bp;
      len++;
    end
    f[len] = ~bs;
    len = len + 2;
    for (int i = 0; i < len; i++) begin
      @(negedge clk);
      line_out = f[i];
      repeat (RX_CYC - 1) @(negedge clk);
    end
  endtask

  // Samples one frame from the device at bit centres
  task automatic recv(input int n, input logic pe, output logic [7:0] d,
    output logic p, output logic stp);
    int t;
    d = 8'h00;
    p = 1'b0;
    t = 0;
    while (line_in !== 1'b0 && t < 400) begin
      @(negedge clk);
      t++;
    end
    repeat (TX_CYC / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (TX_CYC) @(negedge clk);
      d[i] = line_in;
    end
    if (pe) begin
      repeat (TX_CYC) @(negedge clk);
      p = line_in;
    end
    repeat (TX_CYC) @(negedge clk);
    stp = line_in;
  endtask
endmodule

// ==== dv/alr_line_if_bench.sv ====
`timescale 1ns/1ps
module alr_line_if_bench;
  import alr_pkg::*;
  localparam int RXC = 12;
  localparam int TXC = 8;
  logic SYS_CLK, RESET, REG_RD, REG_WR, CFG_PARITY_EN, CFG_PARITY_ODD;
  logic CFG_TWO_STOP, TX_LINE, XMIT_IRQ, READER_ADVANCE, rx_jam, term_line;
  logic [1:0] REG_SEL, CFG_DATA_SEL;
  logic [15:0] REG_WDATA, REG_RDATA, v;
  logic [7:0] d, m, gd, gd2;
  logic gp, gs, gp2, gs2;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Jam lets loopback prove the external line is ignored
  wire RX_LINE = term_line & ~rx_jam;

  alr_line_if #(.RX_BIT_CYC(RXC), .TX_BIT_CYC(TXC)) dut (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_SEL(REG_SEL), .REG_RD(REG_RD),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CFG_DATA_SEL(CFG_DATA_SEL), .CFG_PARITY_EN(CFG_PARITY_EN),
    .CFG_PARITY_ODD(CFG_PARITY_ODD), .CFG_TWO_STOP(CFG_TWO_STOP),
    .RX_LINE(RX_LINE), .TX_LINE(TX_LINE), .XMIT_IRQ(XMIT_IRQ),
    .READER_ADVANCE(READER_ADVANCE));
  alr_term #(.TX_CYC(TXC), .RX_CYC(RXC)) term (
    .clk(SYS_CLK), .line_out(term_line), .line_in(TX_LINE));

  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [15:0] w);
    @(negedge SYS_CLK);
    REG_SEL = s;
    REG_WDATA = w;
    REG_WR = 1'b1;
    @(negedge SYS_CLK);
    REG_WR = 1'b0;
  endtask

  task automatic rd(input logic [1:0] s, output logic [15:0] r);
    @(negedge SYS_CLK);
    REG_SEL = s;
    REG_RD = 1'b1;
    @(negedge SYS_CLK);
    REG_RD = 1'b0;
    r = REG_RDATA;
  endtask

  task automatic rand_cfg();
    CFG_DATA_SEL = 2'($urandom);
    CFG_PARITY_EN = 1'($urandom);
    CFG_PARITY_ODD = 1'($urandom);
    CFG_TWO_STOP = 1'($urandom);
  endtask

  function automatic logic [15:0] rx_exp(input logic [7:0] x,
    input logic o, input logic f, input logic p);
    return {o | f | p, o, f, p, 4'h0, x & (8'hFF >> (2'h3 - CFG_DATA_SEL))};
  endfunction

  // Sends one character, checks done, contents and the clearing read
  task automatic rx_one(input logic bp, input logic bs, input logic o);
    logic [7:0] x;
    x = 8'($urandom);
    term.send(x, 5 + CFG_DATA_SEL, CFG_PARITY_EN, CFG_PARITY_ODD, bp, bs);
    rd(REG_RX_CTL, v);
    chk("done set", 16'h0080, v & 16'h0080);
    rd(REG_RX_CHAR, v);
    chk("rx char", rx_exp(x, o, bs, bp & CFG_PARITY_EN), v);
    rd(REG_RX_CTL, v);
    chk("done clr", 16'h0000, v & 16'h0080);
  endtask

  initial begin
    {REG_SEL, REG_RD, REG_WR, REG_WDATA, rx_jam} = '0;
    {CFG_DATA_SEL, CFG_PARITY_EN, CFG_PARITY_ODD, CFG_TWO_STOP} = 5'h18;
    RESET = 1'b1;
    void'($urandom(20));
    repeat (5) @(negedge SYS_CLK);
    RESET = 1'b0;
    rd(REG_TX_CTL, v);
    chk("tx ctl init", 16'h0080, v);
    rd(REG_RX_CTL, v);
    chk("rx ctl init", 16'h0000, v);
    rd(REG_TX_CHAR, v);
    chk("tx char read", 16'h0000, v);
    wr(REG_TX_CTL, 16'hFFFA);
    rd(REG_TX_CTL, v);
    chk("tx ctl unused", 16'h00C0, v);
    chk("irq on", 16'h0001, {15'h0, XMIT_IRQ});
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      rand_cfg();
      m = 8'hFF >> (2'h3 - CFG_DATA_SEL);
      d = 8'($urandom) & m;
      fork
        term.recv(5 + CFG_DATA_SEL, CFG_PARITY_EN, gd, gp, gs);
        wr(REG_TX_CHAR, {8'($urandom), d});
      join
      chk("tx data", {8'h00, d}, {8'h00, gd});
      if (CFG_PARITY_EN) begin
        chk("tx par", {15'h0, ^d ^ CFG_PARITY_ODD}, {15'h0, gp});
      end
      chk("tx stop", 16'h0001, {15'h0, gs});
    end
    CFG_DATA_SEL = 2'h3;
    CFG_PARITY_EN = 1'b0;
    // Let the last frame drain so the pair starts on an idle shifter
    repeat (2 * TXC) @(negedge SYS_CLK);
    fork
      begin
        term.recv(8, 1'b0, gd, gp, gs);
        term.recv(8, 1'b0, gd2, gp2, gs2);
      end
      begin
        wr(REG_TX_CHAR, 16'h00A5);
        wr(REG_TX_CHAR, 16'h003C);
        rd(REG_TX_CTL, v);
        chk("rdy full", 16'h0040, v & 16'h00C0);
        chk("irq off", 16'h0000, {15'h0, XMIT_IRQ});
      end
    join
    chk("tx pair", 16'hA53C, {gd, gd2});
    repeat (3 * TXC) @(negedge SYS_CLK);
    chk("irq back", 16'h0001, {15'h0, XMIT_IRQ});
    $display("test transmit done");
    rd(REG_RX_CHAR, v);
    term.send(8'h11, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    rx_one(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      rand_cfg();
      rx_one(1'($urandom), ($urandom % 4) == 0, 1'b0);
    end
    $display("test receive done");
    CFG_DATA_SEL = 2'h3;
    CFG_PARITY_EN = 1'b0;
    rx_jam = 1'b1;
    wr(REG_TX_CTL, 16'h0004);
    wr(REG_TX_CHAR, 16'h005A);
    repeat (14 * TXC) @(negedge SYS_CLK);
    rd(REG_RX_CHAR, v);
    chk("loopback", 16'h005A, v);
    wr(REG_TX_CTL, 16'h0000);
    rx_jam = 1'b0;
    $display("test loopback done");
    wr(REG_TX_CTL, 16'h0001);
    repeat (3 * TXC) @(negedge SYS_CLK);
    chk("break", 16'h0000, {15'h0, TX_LINE});
    wr(REG_TX_CTL, 16'h0000);
    repeat (2) @(negedge SYS_CLK);
    chk("break off", 16'h0001, {15'h0, TX_LINE});
    $display("test break done");
    wr(REG_RX_CTL, 16'h0001);
    chk("adv set", 16'h0001, {15'h0, READER_ADVANCE});
    fork
      term.send(8'h77, 8, 1'b0, 1'b0, 1'b0, 1'b0);
      begin
        repeat (3) @(negedge SYS_CLK);
        chk("adv early", 16'h0001, {15'h0, READER_ADVANCE});
        repeat (RXC) @(negedge SYS_CLK);
        chk("adv mid", 16'h0000, {15'h0, READER_ADVANCE});
      end
    join
    wr(REG_RX_CTL, 16'h0001);
    rd(REG_RX_CTL, v);
    chk("adv clr done", 16'h0000, v & 16'h0080);
    @(negedge SYS_CLK);
    RESET = 1'b1;
    @(negedge SYS_CLK);
    RESET = 1'b0;
    chk("adv init", 16'h0000, {15'h0, READER_ADVANCE});
    rd(REG_RX_CHAR, v);
    chk("data kept", 16'h0077, v & 16'h00FF);
    $display("test reader advance done");
    final_report();
  end
endmodule
